// *** hdl/wave_pkg.sv ***
package wave_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int CHANNELS = 2;
  localparam int DIV_W = 10;

  // Register map, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_TIMER_ONE_WAVE_CONTROL_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WAVE_CONTROL_B = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNTER_VALUE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_REG_A = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_REG_B = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE_REG = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS = 8'h18;

  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [2:0] STATUS_RESET = 3'h0;

  // Status bit positions
  localparam int ST_OVERFLOW = 0;
  localparam int ST_MATCH_A = 1;
  localparam int ST_MATCH_B = 2;
  localparam int ST_COUNT_DOWN = 3;

  localparam logic [CNT_W-1:0] BOTTOM = 16'h0000;
  localparam logic [CNT_W-1:0] MAX_COUNT = 16'hFFFF;
  localparam logic [CNT_W-1:0] TOP_8BIT = 16'h00FF;
  localparam logic [CNT_W-1:0] TOP_9BIT = 16'h01FF;
  localparam logic [CNT_W-1:0] TOP_10BIT = 16'h03FF;

  localparam logic [3:0] MODE_PFC_A = 4'h9;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_A = 4'hF;

  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;

  // Tick select codes and divider terminal counts
  localparam logic [2:0] TICK_DIV1 = 3'h1;
  localparam logic [2:0] TICK_DIV8 = 3'h2;
  localparam logic [2:0] TICK_DIV64 = 3'h3;
  localparam logic [2:0] TICK_DIV256 = 3'h4;
  localparam logic [2:0] TICK_DIV1024 = 3'h5;
  localparam logic [DIV_W-1:0] TERM_DIV1 = 10'h000;
  localparam logic [DIV_W-1:0] TERM_DIV8 = 10'h007;
  localparam logic [DIV_W-1:0] TERM_DIV64 = 10'h03F;
  localparam logic [DIV_W-1:0] TERM_DIV256 = 10'h0FF;
  localparam logic [DIV_W-1:0] TERM_DIV1024 = 10'h3FF;

  typedef struct packed {
    logic [1:0] chan_a_output_action;
    logic [1:0] chan_b_output_action;
    logic chan_a_force_strobe;
    logic chan_b_force_strobe;
    logic [1:0] mode_low;
  } ctrl_a_t;

  typedef struct packed {
    logic [2:0] unused;
    logic [1:0] mode_high;
    logic [2:0] tick_select;
  } ctrl_b_t;

  typedef enum {TOP_MAX, TOP_FIX8, TOP_FIX9, TOP_FIX10, TOP_CMP_A, TOP_CAPTURE} top_src_t;
  typedef enum {WAVE_PLAIN, WAVE_FAST, WAVE_DUAL} wave_kind_t;
  typedef enum {EV_NOW, EV_MAX, EV_TOP, EV_BOTTOM} event_at_t;

  typedef struct packed {
    top_src_t top_src;
    wave_kind_t kind;
    event_at_t update_at;
    event_at_t overflow_at;
  } mode_info_t;

  function automatic mode_info_t decode_mode(input logic [3:0] mode);
    mode_info_t m;
    m = '{TOP_MAX, WAVE_PLAIN, EV_NOW, EV_MAX};
    unique case (mode)
      4'h0: m = '{TOP_MAX, WAVE_PLAIN, EV_NOW, EV_MAX};
      4'h1: m = '{TOP_FIX8, WAVE_DUAL, EV_TOP, EV_BOTTOM};
      4'h2: m = '{TOP_FIX9, WAVE_DUAL, EV_TOP, EV_BOTTOM};
      4'h3: m = '{TOP_FIX10, WAVE_DUAL, EV_TOP, EV_BOTTOM};
      4'h4: m = '{TOP_CMP_A, WAVE_PLAIN, EV_NOW, EV_MAX};
      4'h5: m = '{TOP_FIX8, WAVE_FAST, EV_TOP, EV_TOP};
      4'h6: m = '{TOP_FIX9, WAVE_FAST, EV_TOP, EV_TOP};
      4'h7: m = '{TOP_FIX10, WAVE_FAST, EV_TOP, EV_TOP};
      4'h8: m = '{TOP_CAPTURE, WAVE_DUAL, EV_BOTTOM, EV_BOTTOM};
      4'h9: m = '{TOP_CMP_A, WAVE_DUAL, EV_BOTTOM, EV_BOTTOM};
      4'hA: m = '{TOP_CAPTURE, WAVE_DUAL, EV_TOP, EV_BOTTOM};
      4'hB: m = '{TOP_CMP_A, WAVE_DUAL, EV_TOP, EV_BOTTOM};
      4'hC: m = '{TOP_CAPTURE, WAVE_PLAIN, EV_NOW, EV_MAX};
      4'hD: m = '{TOP_MAX, WAVE_PLAIN, EV_NOW, EV_MAX};
      4'hE: m = '{TOP_CAPTURE, WAVE_FAST, EV_TOP, EV_TOP};
      4'hF: m = '{TOP_CMP_A, WAVE_FAST, EV_TOP, EV_TOP};
    endcase
    return m;
  endfunction

endpackage

// *** hdl/wave_timer.sv ***
`timescale 1ns/1ps
// How it works
// - Timer tick is a clock enable on clk, never a clock of its own.
// - Phase-and-frequency-correct modes load buffered compare values at bottom.
// - Nonzero action field routes channel output to pin; software sets pin direction.
// - Non-PWM codes: 00 off, 01 toggle, 10 low, 11 high on match.
// - Fast PWM code 01 toggles A only in mode 15; else disconnected.
// - Fast PWM 10 clears on match, sets at top; 11 the reverse.
// - Fast PWM with compare equal top ignores match, acts only at top.
// - Dual-slope code 01 toggles A only in mode 9; else disconnected.
// - Dual-slope 10 clears on up-match, sets on down-match; 11 reverse.
// - Force strobes act only in non-PWM modes; software writes them zero otherwise.
// - Force strobe is a one-shot immediate match using the action code written with it.
// - Forced match raises no flag and never clears the counter.
// - Force strobe bits always read back as zero.
// - Wave mode is two low bits here plus two high bits elsewhere.
// - Mode 0 counts to 0xFFFF, immediate update, overflow at maximum.
// - Modes 1-3 dual-slope with fixed tops, update at top, overflow at bottom.
// - Modes 4 and 12 clear on match, top from compare A or capture.
// - Fast PWM modes 5-7, 14, 15 update and overflow at top.
// - Modes 8 and 9 update and overflow at bottom.
// - Modes 10 and 11 update at top, overflow at bottom.
// - Bottom is zero; dual slope runs bottom to top and back.
// - Dual slope holds top for exactly one tick before turning.
module wave_timer
  import wave_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic chan_a_wave_out,
  output logic chan_b_wave_out,
  output logic chan_a_pin_override,
  output logic chan_b_pin_override
);

  ctrl_a_t ctrl_a_reg;
  ctrl_b_t ctrl_b_reg;
  logic [CNT_W-1:0] counter_value_reg;
  logic [CNT_W-1:0] capture_reg;
  logic [CNT_W-1:0] cmp_buf_reg [CHANNELS];
  logic [CNT_W-1:0] cmp_act_reg [CHANNELS];
  logic [CHANNELS-1:0] wave_reg;
  logic [2:0] status_reg;
  logic count_down_reg;
  logic block_match_reg;
  logic [DIV_W-1:0] div_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [DATA_W-1:0] prdata_reg;

  logic [3:0] wave_mode_select;
  mode_info_t info;
  logic [CNT_W-1:0] top_val;
  logic [DIV_W-1:0] div_term;
  logic tick;
  logic at_top;
  logic at_bottom;
  logic overflow_ev;
  logic update_ev;
  logic access;
  logic wr_en;
  logic addr_ok;
  logic wr_ctrl_a;
  logic [DATA_W-1:0] rd_data;
  logic [CHANNELS-1:0] match_ev;
  logic [CHANNELS-1:0] force_ev;
  logic [CHANNELS-1:0] connected;
  logic [1:0] act [CHANNELS];
  logic [1:0] new_act [CHANNELS];
  logic [CHANNELS-1:0] new_force;
  ctrl_a_t wr_ctrl_a_val;
  mode_info_t new_info;

  // Bus decode: one wait state, so answers come from flops
  assign access = psel && penable;
  assign wr_en = access && pwrite && pready_reg && !pslverr_reg;
  assign wr_ctrl_a = wr_en && (paddr == OFS_TIMER_ONE_WAVE_CONTROL_A);
  assign wr_ctrl_a_val = ctrl_a_t'(pwdata[7:0]);

  always_comb
  begin
    addr_ok = 1'b1;
    unique case (paddr)
      OFS_TIMER_ONE_WAVE_CONTROL_A, OFS_WAVE_CONTROL_B, OFS_COUNTER_VALUE,
      OFS_COMPARE_REG_A, OFS_COMPARE_REG_B, OFS_CAPTURE_REG, OFS_EVENT_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= access && !pready_reg;
      pslverr_reg <= access && !pready_reg && !addr_ok;
    end
  end

  always_comb
  begin
    rd_data = '0;
    unique case (paddr)
      OFS_TIMER_ONE_WAVE_CONTROL_A:
      begin
        rd_data[7:0] = ctrl_a_reg;
        rd_data[3:2] = 2'h0;
      end
      OFS_WAVE_CONTROL_B: rd_data[7:0] = ctrl_b_reg;
      OFS_COUNTER_VALUE: rd_data[CNT_W-1:0] = counter_value_reg;
      OFS_COMPARE_REG_A: rd_data[CNT_W-1:0] = cmp_buf_reg[0];
      OFS_COMPARE_REG_B: rd_data[CNT_W-1:0] = cmp_buf_reg[1];
      OFS_CAPTURE_REG: rd_data[CNT_W-1:0] = capture_reg;
      OFS_EVENT_STATUS: rd_data[ST_COUNT_DOWN:0] = {count_down_reg, status_reg};
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata_reg <= '0;
    else if (access && !pready_reg && !pwrite)
      prdata_reg <= rd_data;
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  // Control registers; force bits are never stored
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_a_reg <= ctrl_a_t'(CTRL_A_RESET);
    else if (wr_ctrl_a)
    begin
      ctrl_a_reg <= wr_ctrl_a_val;
      ctrl_a_reg.chan_a_force_strobe <= 1'b0;
      ctrl_a_reg.chan_b_force_strobe <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_b_reg <= ctrl_b_t'(CTRL_B_RESET);
    else if (wr_en && (paddr == OFS_WAVE_CONTROL_B))
    begin
      ctrl_b_reg <= ctrl_b_t'(pwdata[7:0]);
      ctrl_b_reg.unused <= 3'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      capture_reg <= CNT_RESET;
    else if (wr_en && (paddr == OFS_CAPTURE_REG))
      capture_reg <= pwdata[CNT_W-1:0];
  end

  assign wave_mode_select = {ctrl_b_reg.mode_high, ctrl_a_reg.mode_low};
  assign info = decode_mode(wave_mode_select);
  assign new_info = decode_mode({ctrl_b_reg.mode_high, wr_ctrl_a_val.mode_low});

  always_comb
  begin
    top_val = MAX_COUNT;
    unique case (info.top_src)
      TOP_MAX: top_val = MAX_COUNT;
      TOP_FIX8: top_val = TOP_8BIT;
      TOP_FIX9: top_val = TOP_9BIT;
      TOP_FIX10: top_val = TOP_10BIT;
      TOP_CMP_A: top_val = cmp_act_reg[0];
      TOP_CAPTURE: top_val = capture_reg;
    endcase
  end
  // Prescaler: tick is an enable pulse; external clock codes stop the timer
  always_comb
  begin
    div_term = TERM_DIV1;
    unique case (ctrl_b_reg.tick_select)
      TICK_DIV8: div_term = TERM_DIV8;
      TICK_DIV64: div_term = TERM_DIV64;
      TICK_DIV256: div_term = TERM_DIV256;
      TICK_DIV1024: div_term = TERM_DIV1024;
      default: div_term = TERM_DIV1;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      div_reg <= '0;
    else if (tick || (ctrl_b_reg.tick_select < TICK_DIV1) || (ctrl_b_reg.tick_select > TICK_DIV1024))
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end

  assign tick = (ctrl_b_reg.tick_select >= TICK_DIV1) && (ctrl_b_reg.tick_select <= TICK_DIV1024)
    && (div_reg == div_term);

  assign at_top = (counter_value_reg == top_val);
  assign at_bottom = (counter_value_reg == BOTTOM);

  always_comb
  begin
    overflow_ev = 1'b0;
    unique case (info.overflow_at)
      EV_MAX: overflow_ev = counter_value_reg == MAX_COUNT;
      EV_TOP: overflow_ev = at_top;
      EV_BOTTOM: overflow_ev = at_bottom;
      EV_NOW: overflow_ev = 1'b0;
    endcase
    update_ev = 1'b1;
    unique case (info.update_at)
      EV_NOW: update_ev = 1'b1;
      EV_TOP: update_ev = tick && at_top;
      EV_BOTTOM: update_ev = tick && at_bottom;
      EV_MAX: update_ev = 1'b0;
    endcase
  end
  // Counter; a software write suppresses the next tick's matches
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      counter_value_reg <= CNT_RESET;
      count_down_reg <= 1'b0;
    end
    else if (wr_en && (paddr == OFS_COUNTER_VALUE))
      counter_value_reg <= pwdata[CNT_W-1:0];
    else if (tick)
    begin
      if (info.kind != WAVE_DUAL)
      begin
        count_down_reg <= 1'b0;
        counter_value_reg <= at_top ? BOTTOM : counter_value_reg + 1'b1;
      end
      else if (!count_down_reg)
      begin
        // Top is shown for one tick, then the count turns
        if (counter_value_reg >= top_val)
        begin
          count_down_reg <= 1'b1;
          counter_value_reg <= counter_value_reg - 1'b1;
        end
        else
          counter_value_reg <= counter_value_reg + 1'b1;
      end
      else if (at_bottom)
      begin
        count_down_reg <= 1'b0;
        counter_value_reg <= counter_value_reg + 1'b1;
      end
      else
        counter_value_reg <= counter_value_reg - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      block_match_reg <= 1'b0;
    else if (wr_en && (paddr == OFS_COUNTER_VALUE))
      block_match_reg <= 1'b1;
    else if (tick)
      block_match_reg <= 1'b0;
  end

  assign new_act[0] = wr_ctrl_a_val.chan_a_output_action;
  assign new_act[1] = wr_ctrl_a_val.chan_b_output_action;
  assign new_force = {wr_ctrl_a_val.chan_b_force_strobe, wr_ctrl_a_val.chan_a_force_strobe};
  assign act[0] = ctrl_a_reg.chan_a_output_action;
  assign act[1] = ctrl_a_reg.chan_b_output_action;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
      logic toggle_ok;

      always_comb
      begin
        toggle_ok = 1'b1;
        unique case (info.kind)
          WAVE_PLAIN: toggle_ok = 1'b1;
          WAVE_FAST: toggle_ok = (ch == 0) && (wave_mode_select == MODE_FAST_A);
          WAVE_DUAL: toggle_ok = (ch == 0) &&
            ((wave_mode_select == MODE_PFC_A) || (wave_mode_select == MODE_FAST_CAP));
        endcase
      end

      assign connected[ch] = (act[ch] != ACT_OFF) && !((act[ch] == ACT_TOGGLE) && !toggle_ok);
      assign match_ev[ch] = tick && !block_match_reg && (counter_value_reg == cmp_act_reg[ch]);
      // Force uses the action code and mode written with it; ignored in PWM modes
      assign force_ev[ch] = wr_ctrl_a && new_force[ch]
        && (new_info.kind == WAVE_PLAIN);

      always_ff @(posedge clk)
      begin
        if (!rst_n)
          cmp_buf_reg[ch] <= CNT_RESET;
        else if (wr_en && (paddr == (ch == 0 ? OFS_COMPARE_REG_A : OFS_COMPARE_REG_B)))
          cmp_buf_reg[ch] <= pwdata[CNT_W-1:0];
      end

      // Buffered compare value goes active at the mode's update point
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          cmp_act_reg[ch] <= CNT_RESET;
        else if (update_ev)
          cmp_act_reg[ch] <= cmp_buf_reg[ch];
      end

      always_ff @(posedge clk)
      begin
        if (!rst_n)
          wave_reg[ch] <= 1'b0;
        else if (force_ev[ch])
        begin
          unique case (new_act[ch])
            ACT_TOGGLE: wave_reg[ch] <= ~wave_reg[ch];
            ACT_LOW: wave_reg[ch] <= 1'b0;
            ACT_HIGH: wave_reg[ch] <= 1'b1;
            ACT_OFF: wave_reg[ch] <= wave_reg[ch];
          endcase
        end
        else
        begin
          unique case (info.kind)
            WAVE_PLAIN:
            begin
              if (match_ev[ch])
              begin
                unique case (act[ch])
                  ACT_TOGGLE: wave_reg[ch] <= ~wave_reg[ch];
                  ACT_LOW: wave_reg[ch] <= 1'b0;
                  ACT_HIGH: wave_reg[ch] <= 1'b1;
                  ACT_OFF: wave_reg[ch] <= wave_reg[ch];
                endcase
              end
            end
            WAVE_FAST:
            begin
              if ((act[ch] == ACT_TOGGLE) && toggle_ok && match_ev[ch])
                wave_reg[ch] <= ~wave_reg[ch];
              else if (act[ch][1] && tick && at_top)
                wave_reg[ch] <= ~act[ch][0];
              else if (act[ch][1] && match_ev[ch] && (cmp_act_reg[ch] != top_val))
                wave_reg[ch] <= act[ch][0];
            end
            WAVE_DUAL:
            begin
              if ((act[ch] == ACT_TOGGLE) && toggle_ok && match_ev[ch])
                wave_reg[ch] <= ~wave_reg[ch];
              else if (act[ch][1] && match_ev[ch])
                wave_reg[ch] <= count_down_reg ? ~act[ch][0] : act[ch][0];
            end
          endcase
        end
      end
    end
  endgenerate

  // Flags come from real overflows and matches only, never forced ones; set wins over a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      status_reg <= STATUS_RESET;
    else
    begin
      status_reg[ST_OVERFLOW] <= (tick && overflow_ev) || (status_reg[ST_OVERFLOW] &&
        !(wr_en && (paddr == OFS_EVENT_STATUS) && pwdata[ST_OVERFLOW]));
      status_reg[ST_MATCH_A] <= match_ev[0] || (status_reg[ST_MATCH_A] &&
        !(wr_en && (paddr == OFS_EVENT_STATUS) && pwdata[ST_MATCH_A]));
      status_reg[ST_MATCH_B] <= match_ev[1] || (status_reg[ST_MATCH_B] &&
        !(wr_en && (paddr == OFS_EVENT_STATUS) && pwdata[ST_MATCH_B]));
    end
  end

  assign chan_a_wave_out = wave_reg[0];
  assign chan_b_wave_out = wave_reg[1];
  assign chan_a_pin_override = connected[0];
  assign chan_b_pin_override = connected[1];

endmodule

// *** dv/wave_timer_chk.sv ***
`timescale 1ns/1ps
module wave_timer_chk
  import wave_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chan_a_wave_out,
  input wire logic chan_b_wave_out,
  input wire logic chan_a_pin_override,
  input wire logic chan_b_pin_override
);
  logic [7:0] ca_reg;
  logic [7:0] cb_reg;
  logic wa;
  logic wb;
  logic [3:0] mode;
  logic [3:0] nmode;
  logic pwm;
  logic npwm;
  logic stop;
  logic ovr_a;
  logic ovr_b;

  assign wa = psel && penable && pready && pwrite && paddr == OFS_TIMER_ONE_WAVE_CONTROL_A;
  assign wb = psel && penable && pready && pwrite && paddr == OFS_WAVE_CONTROL_B;
  assign mode = {cb_reg[4:3], ca_reg[1:0]};
  assign nmode = {cb_reg[4:3], pwdata[1:0]};
  assign pwm = !(mode inside {4'h0, 4'h4, 4'hC, 4'hD});
  assign npwm = !(nmode inside {4'h0, 4'h4, 4'hC, 4'hD});
  assign stop = cb_reg[2:0] == 3'h0 || cb_reg[2:0] > TICK_DIV1024;
  // Toggle code keeps the pin only where a toggle is defined
  assign ovr_a = ca_reg[7:6] != ACT_OFF && (ca_reg[7:6] != ACT_TOGGLE || !pwm
                 || mode == MODE_FAST_A || mode == MODE_PFC_A);
  assign ovr_b = ca_reg[5:4] != ACT_OFF && (ca_reg[5:4] != ACT_TOGGLE || !pwm);

  // Shadow copies of both control words
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ca_reg <= 8'h00;
    else if (wa)
      ca_reg <= pwdata[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cb_reg <= 8'h00;
    else if (wb)
      cb_reg <= pwdata[7:0];
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_rdy_wait;
    psel && !penable |=> !pready ##1 pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("pready not on second access cycle");

  property p_err_map;
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > OFS_EVENT_STATUS);
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr does not match address");

  property p_force_rd;
    pready && !pwrite && paddr == OFS_TIMER_ONE_WAVE_CONTROL_A |-> prdata[3:2] == 2'h0;
  endproperty
  a_force_rd: assert property (p_force_rd) else $error("force bits read nonzero");

  property p_ovr_a;
    chan_a_pin_override == ovr_a;
  endproperty
  a_ovr_a: assert property (p_ovr_a) else $error("chan a pin takeover wrong");

  property p_ovr_b;
    chan_b_pin_override == ovr_b;
  endproperty
  a_ovr_b: assert property (p_ovr_b) else $error("channel b pin takeover wrong");

  property p_force_lvl;
    wa && pwdata[3] && pwdata[7] && !npwm |=> chan_a_wave_out == $past(pwdata[6]);
  endproperty
  a_force_lvl: assert property (p_force_lvl) else $error("forced level wrong");

  property p_force_tog;
    wa && pwdata[2] && pwdata[5:4] == ACT_TOGGLE && !npwm && stop
      |=> chan_b_wave_out != $past(chan_b_wave_out);
  endproperty
  a_force_tog: assert property (p_force_tog) else $error("forced toggle missing");

  property p_force_pwm;
    wa && npwm && stop |=> $stable(chan_a_wave_out) && $stable(chan_b_wave_out);
  endproperty
  a_force_pwm: assert property (p_force_pwm) else $error("force acted in pwm mode");

  property p_stop_hold;
    stop && !wa |=> $stable(chan_a_wave_out) && $stable(chan_b_wave_out);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("output moved without tick");

  c_force: cover property (wa && pwdata[3] && !npwm);
  c_pwm_pin: cover property (chan_a_pin_override && pwm);
  c_err: cover property (pready && pslverr);
endmodule

bind wave_timer wave_timer_chk u_chk (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chan_a_wave_out(chan_a_wave_out), .chan_b_wave_out(chan_b_wave_out),
  .chan_a_pin_override(chan_a_pin_override), .chan_b_pin_override(chan_b_pin_override)
);

// *** dv/wave_timer_tb.sv ***
`timescale 1ns/1ps
module wide_timer_waveform_control_tb_top;
  import wave_pkg::*;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic oa;
  logic ob;
  logic va;
  logic vb;
  logic [DATA_W-1:0] r;
  logic e;
  int n_mismatch;
  int checks_done;
  int cyc;

  wave_timer u_wave_timer (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_a_wave_out(oa), .chan_b_wave_out(ob),
    .chan_a_pin_override(va), .chan_b_pin_override(vb)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, well above the longest sequence
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic ck(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      ck("pready", 32'h1, 32'h0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Let the write edge land before looking
  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic t_reset;
    apb(1'b0, OFS_TIMER_ONE_WAVE_CONTROL_A, 32'h0);
    ck("ctrl_a", 32'h0, r);
    apb(1'b0, OFS_WAVE_CONTROL_B, 32'h0);
    ck("ctrl_b", 32'h0, r);
    apb(1'b0, OFS_EVENT_STATUS, 32'h0);
    ck("status", 32'h0, r);
    apb(1'b1, 8'h20, 32'h0000_00FF);
    ck("slverr", 32'h1, 32'(e));
    apb(1'b1, OFS_WAVE_CONTROL_B, 32'h0000_00E0);
    apb(1'b0, OFS_WAVE_CONTROL_B, 32'h0);
    ck("ctrl_b", 32'h0, r);
  endtask

  task automatic t_force;
    apb(1'b1, OFS_TIMER_ONE_WAVE_CONTROL_A, 32'h0000_00CC);
    settle();
    ck("out_a", 32'h1, 32'(oa));
    ck("ovr_a", 32'h1, 32'(va));
    ck("ovr_b", 32'h0, 32'(vb));
    apb(1'b0, OFS_TIMER_ONE_WAVE_CONTROL_A, 32'h0);
    ck("ctrl_a", 32'h0000_00C0, r);
    apb(1'b1, OFS_TIMER_ONE_WAVE_CONTROL_A, 32'h0000_0098);
    settle();
    ck("out_a", 32'h0, 32'(oa));
    ck("out_b", 32'h0, 32'(ob));
    apb(1'b1, OFS_TIMER_ONE_WAVE_CONTROL_A, 32'h0000_0014);
    settle();
    ck("out_b", 32'h1, 32'(ob));
    ck("ovr_a", 32'h0, 32'(va));
    apb(1'b1, OFS_COUNTER_VALUE, 32'h0000_0005);
    apb(1'b1, OFS_WAVE_CONTROL_B, 32'h0000_0008);
    apb(1'b1, OFS_TIMER_ONE_WAVE_CONTROL_A, 32'h0000_0048);
    settle();
    ck("out_a", 32'h1, 32'(oa));
    apb(1'b0, OFS_COUNTER_VALUE, 32'h0);
    ck("counter", 32'h0000_0005, r);
    apb(1'b0, OFS_EVENT_STATUS, 32'h0);
    ck("status", 32'h0, r);
  endtask

  task automatic t_pwm_force;
    apb(1'b1, OFS_TIMER_ONE_WAVE_CONTROL_A, 32'h0000_0089);
    settle();
    ck("out_a", 32'h1, 32'(oa));
    ck("ovr_a", 32'h1, 32'(va));
    apb(1'b1, OFS_TIMER_ONE_WAVE_CONTROL_A, 32'h0000_0042);
    apb(1'b1, OFS_WAVE_CONTROL_B, 32'h0000_0018);
    settle();
    ck("ovr_a", 32'h0, 32'(va));
  endtask

  task automatic t_wave;
    logic [3:0] md[8] = '{4'h5, 4'h5, 4'h5, 4'h1, 4'h1, 4'h4, 4'hF, 4'h9};
    logic [1:0] cd[8] = '{2'h2, 2'h3, 2'h2, 2'h2, 2'h3, 2'h1, 2'h1, 2'h1};
    logic [15:0] cp[8] = '{16'h0010, 16'h0010, 16'h00FF, 16'h0040, 16'h0040, 16'h001F,
                           16'h003F, 16'h0040};
    int wn[8] = '{256, 256, 256, 510, 510, 64, 128, 256};
    int hi[8] = '{17, 239, 256, 128, 382, 32, 64, 128};
    int n;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, OFS_WAVE_CONTROL_B, 32'h0);
      apb(1'b1, OFS_EVENT_STATUS, 32'h0000_0007);
      apb(1'b1, OFS_TIMER_ONE_WAVE_CONTROL_A, 32'h0);
      apb(1'b1, OFS_COMPARE_REG_A, {16'h0000, cp[i]});
      apb(1'b1, OFS_COUNTER_VALUE, 32'h0);
      apb(1'b1, OFS_TIMER_ONE_WAVE_CONTROL_A, {24'h00_0000, cd[i], 4'h0, md[i][1:0]});
      apb(1'b1, OFS_WAVE_CONTROL_B, {27'h0, md[i][3:2], TICK_DIV1});
      repeat (600) @(negedge clk);
      n = 0;
      repeat (wn[i])
      begin
        @(negedge clk);
        if (oa === 1'b1)
          n++;
      end
      ck("high_cycles", 32'(hi[i]), 32'(n));
      ck("ovr_a", 32'h1, 32'(va));
      // Flags were cleared before the run, so each mode must set them anew, except overflow in mode 4
      apb(1'b0, OFS_EVENT_STATUS, 32'h0);
      ck("overflow", 32'(md[i] != 4'h4), 32'(r[ST_OVERFLOW]));
      ck("match_a", 32'h1, 32'(r[ST_MATCH_A]));
    end
  endtask

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_mismatch = 0;
    checks_done = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_force();
    t_pwm_force();
    t_wave();
    test_done();
  end
endmodule
